/* design/retimer_lane_mode_control_consts.svh */
// Offsets, field positions, reset values and encodings of the lane and mode control registers.
`ifndef RETIMER_LANE_MODE_CONTROL_CONSTS_SVH
`define RETIMER_LANE_MODE_CONTROL_CONSTS_SVH

`define LANE_POWER_CTL_OFFSET   8'h09
`define LINK_MODE_CTL_OFFSET    8'h0a

`define LANE_POWER_CTL_RESET    8'h02
`define LINK_MODE_CTL_RESET     8'hb1

`define LP_SWAP_BIT             7
`define LP_POLARITY_BIT         6
`define LP_ACTIVITY_BIT         4
`define LP_POWERDOWN_BIT        3
`define LP_SLEEP_INHIBIT_BIT    2
`define LP_RATE_MSB             1
`define LP_RATE_LSB             0

`define LM_SINK_BIT             7
`define LM_PASSTHRU_BLOCK_BIT   6
`define LM_ADAPTIVE_BIT         5
`define LM_EQ_ON_BIT            4
`define LM_COMMIT_BIT           2
`define LM_MODE_MSB             1
`define LM_MODE_LSB             0

`define RATE_RESET              2'h2
`define RATE_400K               2'h3
`define MODE_REDRIVER           2'h0
`define MODE_AUTO_CROSSOVER     2'h1
`define MODE_RESERVED           2'h2
`define MODE_RETIMER            2'h3
`define MODE_RESET              2'h1

`endif

/* design/retimer_lane_mode_control_pkg.sv */
// Types shared by the lane and mode control register bank.
package retimer_lane_mode_control_pkg;

  // Decoded content of the lane and power control register.
  typedef struct packed {
    logic       laneSwap;
    logic       polarityInvert;
    logic       activityDetectEnable;
    logic       forcedPowerdown;
    logic       plugSenseSleepInhibit;
    logic [1:0] configBusRate;
  } lane_power_s;

  // Decoded content of the link mode control register.
  typedef struct packed {
    logic       sinkMode;
    logic       plugPassthruBlock;
    logic       adaptiveEqualizerSelect;
    logic       equalizerOn;
    logic [1:0] operatingModeSel;
  } link_mode_s;

  // Equalizer settings that reach the lanes through a commit, or directly while the link is idle.
  typedef struct packed {
    logic equalizerOn;
    logic adaptiveEqualizerSelect;
  } lane_eq_s;

endpackage : retimer_lane_mode_control_pkg

/* design/retimer_lane_mode_control.sv */
// Lane swap, power, equalizer and operating mode control registers of the retimer.
//
// Notes on behaviour
// - Lane swap bit, reset off, both modes.
// - Polarity inversion bit, reset off, any mode but redriver.
// - Swap and polarity load from strap; pin mode.
// - Activity detect from strap; standby without data.
// - Forced powerdown bit enters lowest power state.
// - Clear inhibit: power down follows plug detect.
// - Config bus rate field, reset 100 Kbps.
// - Application side bit, reset sink.
// - Passthru block holds plug output deasserted.
// - Equalizer type bit, reset adaptive, host mode.
// - Equalizer enable bit, reset on, host mode.
// - Self-clearing commit applies staged lane settings.
// - No commit needed while idle or down.
// - Operating mode field, reset auto crossover.
// - Register access only with host select high.
// - Reserved bits read zero, ignore writes.
`timescale 1ns/1ns
`include "retimer_lane_mode_control_consts.svh"

module retimer_lane_mode_control
  import retimer_lane_mode_control_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  input  wire logic       hostConfigSelect,
  input  wire logic       exchangeStrapPin,
  input  wire logic       activityStrapPin,
  input  wire logic       plugDetectIn,
  input  wire logic       outputEnablePin,
  input  wire logic       linkClockPresent,
  output logic            laneSwap,
  output logic            polarityInvert,
  output logic            activityDetectEnable,
  output logic            powerDown,
  output logic      [1:0] configBusRate,
  output logic            sinkMode,
  output logic            plugDetectOut,
  output logic            equalizerOn,
  output logic            adaptiveEqualizerSelect,
  output logic      [1:0] operatingModeSel,
  output logic            commitPulse
);

  // The six pin inputs come from the board, not from this clock domain.
  // Straps, host select, plug detect, output enable and link clock presence can all
  // change at any moment relative to core_clk, so a first stage may go metastable.
  // Only the second stage feeds any logic, which gives the first a full cycle to settle.
  // The cost is two cycles of latency on every pin, which the host never notices
  // at configuration bus speeds.
  // The synchroniser clears to zero in reset, so the bank starts in pin mode.
  // Straps therefore load into their fields for the first cycles after reset.
  // Host select must then be seen high for two edges before writes are accepted.
  // A host that writes at once after reset release loses that write.
  // Pin inputs pass two flip-flops; only the second stage is read.
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinMeta <= 6'h00;
      pinSync <= 6'h00;
    end else begin
      pinMeta <= {hostConfigSelect, exchangeStrapPin, activityStrapPin,
                  plugDetectIn, outputEnablePin, linkClockPresent};
      pinSync <= pinMeta;
    end
  end

  // Synchronised pin levels, split out by name.
  // The order of the split must match the order of the concatenation above.
  logic hostSel;
  logic strapSwap;
  logic strapActivity;
  logic plugIn;
  logic oeIn;
  logic linkClk;
  assign {hostSel, strapSwap, strapActivity, plugIn, oeIn, linkClk} = pinSync;

  // Register state, applied lane state and registered outputs.
  lane_power_s lpReg,      lpNext;
  link_mode_s  lmReg,      lmNext;
  lane_eq_s    eqReg,      eqNext;
  logic [1:0]  modeReg,    modeNext;
  logic        fpdPrevReg, fpdPrevNext;
  logic        plugPrevReg, plugPrevNext;
  logic [7:0]  rdReg,      rdNext;
  logic        commitReg,  commitNext;
  logic        swapReg,    swapNext;
  logic        polReg,     polNext;
  logic        pdReg,      pdNext;
  logic        plugOutReg, plugOutNext;

  // Decoded strobes and apply conditions, all computed in the next-state process.
  // They are plain combinational helpers and hold no state of their own.
  // Keeping them named makes the write, commit and reload paths easy to follow.
  logic wrLp;
  logic wrLm;
  logic commitReq;
  logic noCommitNeeded;
  logic modeReload;

  // Next-state logic for the whole bank; the strap fields track their pins in pin mode.
  always_comb begin
    lpNext      = lpReg;
    lmNext      = lmReg;
    eqNext      = eqReg;
    modeNext    = modeReg;
    rdNext      = rdReg;
    fpdPrevNext = lpReg.forcedPowerdown;
    plugPrevNext = plugIn;

    wrLp = regWrite && hostSel && (regAddr == `LANE_POWER_CTL_OFFSET);
    wrLm = regWrite && hostSel && (regAddr == `LINK_MODE_CTL_OFFSET);

    // In pin mode the strap-loaded fields follow their pins on every cycle.
    // One exchange strap drives both the swap and the polarity field.
    // Host writes cannot land here in pin mode, since the write strobes need host select.
    // The other fields keep their last value, so leaving host mode loses only the swap, polarity and activity settings.
    if (!hostSel) begin
      lpNext.laneSwap             = strapSwap;
      lpNext.polarityInvert       = strapSwap;
      lpNext.activityDetectEnable = strapActivity;
    end

    // A host write is a whole byte and replaces every stored field at once.
    // The host must read, modify and write back to change a single field.
    // Bit 5 is reserved and has no storage, so writes to it vanish.
    if (wrLp) begin
      lpNext.laneSwap              = regWrData[`LP_SWAP_BIT];
      lpNext.polarityInvert        = regWrData[`LP_POLARITY_BIT];
      lpNext.activityDetectEnable  = regWrData[`LP_ACTIVITY_BIT];
      lpNext.forcedPowerdown       = regWrData[`LP_POWERDOWN_BIT];
      lpNext.plugSenseSleepInhibit = regWrData[`LP_SLEEP_INHIBIT_BIT];
      lpNext.configBusRate         = regWrData[`LP_RATE_MSB:`LP_RATE_LSB];
    end

    // Bit 3 is reserved and the commit bit is not stored.
    if (wrLm) begin
      lmNext.sinkMode                = regWrData[`LM_SINK_BIT];
      lmNext.plugPassthruBlock       = regWrData[`LM_PASSTHRU_BLOCK_BIT];
      lmNext.adaptiveEqualizerSelect = regWrData[`LM_ADAPTIVE_BIT];
      lmNext.equalizerOn             = regWrData[`LM_EQ_ON_BIT];
      lmNext.operatingModeSel        = regWrData[`LM_MODE_MSB:`LM_MODE_LSB];
    end

    // The stored equalizer fields are only staged values; the lanes see the applied copy.
    // A commit copies the staged values held before the commit write itself.
    // So a byte that both commits and changes the equalizer bits applies the old staging,
    // and the new bits wait for the next commit.
    // This keeps the applied copy glitch free while a transfer is in flight.
    // While the link is idle or powered down, no traffic can be disturbed,
    // so the applied copy simply tracks the staged one every cycle.
    // Staged equalizer settings reach the lanes on a commit, or directly while the link is idle.
    commitReq      = wrLm && regWrData[`LM_COMMIT_BIT];
    noCommitNeeded = !oeIn || !plugIn || lpReg.forcedPowerdown
                     || (!linkClk && lpReg.activityDetectEnable);
    if (commitReq || noCommitNeeded) begin
      eqNext.equalizerOn             = lmReg.equalizerOn;
      eqNext.adaptiveEqualizerSelect = lmReg.adaptiveEqualizerSelect;
    end

    // The operating mode reaches the lanes only on a power or plug transition.
    // Changing it under live traffic would retrain the link mid-stream.
    // Either edge of forced powerdown or of plug detect counts as a toggle.
    // The previous values are registered each cycle so a change shows for one cycle.
    // Right after reset the plug history reads low, so a plugged link reloads once.
    // That reload applies the reset mode and changes nothing visible.
    // A new crossover setting takes hold only when powerdown or plug detect toggles.
    // The reserved code is never applied; the lanes keep the previous mode.
    modeReload = (fpdPrevReg != lpReg.forcedPowerdown) || (plugPrevReg != plugIn);
    if (modeReload && (lmReg.operatingModeSel != `MODE_RESERVED)) begin
      modeNext = lmReg.operatingModeSel;
    end

    // A read strobe always updates the read byte, even when it is refused.
    // Refused reads and unmapped offsets answer zero, so no stale byte is returned.
    // Without a strobe the byte stands, which lets the front end shift it out slowly.
    // The read shows the stored fields, so a reserved mode code reads back as written.
    // Read data is registered; reserved bits and the commit bit read zero.
    if (regRead) begin
      rdNext = 8'h00;
      if (hostSel && (regAddr == `LANE_POWER_CTL_OFFSET)) begin
        rdNext[`LP_SWAP_BIT]                 = lpReg.laneSwap;
        rdNext[`LP_POLARITY_BIT]             = lpReg.polarityInvert;
        rdNext[`LP_ACTIVITY_BIT]             = lpReg.activityDetectEnable;
        rdNext[`LP_POWERDOWN_BIT]            = lpReg.forcedPowerdown;
        rdNext[`LP_SLEEP_INHIBIT_BIT]        = lpReg.plugSenseSleepInhibit;
        rdNext[`LP_RATE_MSB:`LP_RATE_LSB]    = lpReg.configBusRate;
      end else if (hostSel && (regAddr == `LINK_MODE_CTL_OFFSET)) begin
        rdNext[`LM_SINK_BIT]                 = lmReg.sinkMode;
        rdNext[`LM_PASSTHRU_BLOCK_BIT]       = lmReg.plugPassthruBlock;
        rdNext[`LM_ADAPTIVE_BIT]             = lmReg.adaptiveEqualizerSelect;
        rdNext[`LM_EQ_ON_BIT]                = lmReg.equalizerOn;
        rdNext[`LM_MODE_MSB:`LM_MODE_LSB]    = lmReg.operatingModeSel;
      end
    end

    // Next values of the registered outputs.
    // Each output has its own flip-flop so that none is driven through logic.
    // This costs one cycle of latency after the field changes.
    commitNext  = commitReq;
    swapNext    = lpReg.laneSwap;
    // Polarity inversion has no effect while the lanes run as a pure redriver.
    polNext     = lpReg.polarityInvert && (modeReg != `MODE_REDRIVER);
    // Plug-sensed sleep is suppressed by the inhibit bit; forced powerdown always wins.
    pdNext      = lpReg.forcedPowerdown || (!lpReg.plugSenseSleepInhibit && !plugIn);
    plugOutNext = plugIn && !lmReg.plugPassthruBlock;
  end

  // Reset is synchronous, so every flip-flop here clears on a clock edge.
  // The stored fields take their documented reset values.
  // The applied copies start equal to them, so no commit is needed after reset.
  // Register stage for the bank; reset values are constants only.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lpReg.laneSwap              <= 1'b0;
      lpReg.polarityInvert        <= 1'b0;
      lpReg.activityDetectEnable  <= 1'b0;
      lpReg.forcedPowerdown       <= 1'b0;
      lpReg.plugSenseSleepInhibit <= 1'b0;
      lpReg.configBusRate         <= `RATE_RESET;
      lmReg.sinkMode                <= 1'b1;
      lmReg.plugPassthruBlock       <= 1'b0;
      lmReg.adaptiveEqualizerSelect <= 1'b1;
      lmReg.equalizerOn             <= 1'b1;
      lmReg.operatingModeSel        <= `MODE_RESET;
      eqReg.equalizerOn             <= 1'b1;
      eqReg.adaptiveEqualizerSelect <= 1'b1;
      modeReg     <= `MODE_RESET;
      fpdPrevReg  <= 1'b0;
      plugPrevReg <= 1'b0;
      rdReg       <= 8'h00;
      commitReg   <= 1'b0;
      swapReg     <= 1'b0;
      polReg      <= 1'b0;
      pdReg       <= 1'b0;
      plugOutReg  <= 1'b0;
    end else begin
      lpReg       <= lpNext;
      lmReg       <= lmNext;
      eqReg       <= eqNext;
      modeReg     <= modeNext;
      fpdPrevReg  <= fpdPrevNext;
      plugPrevReg <= plugPrevNext;
      rdReg       <= rdNext;
      commitReg   <= commitNext;
      swapReg     <= swapNext;
      polReg      <= polNext;
      pdReg       <= pdNext;
      plugOutReg  <= plugOutNext;
    end
  end

  // Fields that need no gating, except lane swap, come out of their register directly.
  // Gated outputs come out of their own flip-flop computed above.
  // Every output is taken straight from a flip-flop.
  assign regRdData               = rdReg;
  assign laneSwap                = swapReg;
  assign polarityInvert          = polReg;
  assign activityDetectEnable    = lpReg.activityDetectEnable;
  assign powerDown               = pdReg;
  assign configBusRate           = lpReg.configBusRate;
  assign sinkMode                = lmReg.sinkMode;
  assign plugDetectOut           = plugOutReg;
  assign equalizerOn             = eqReg.equalizerOn;
  assign adaptiveEqualizerSelect = eqReg.adaptiveEqualizerSelect;
  assign operatingModeSel        = modeReg;
  assign commitPulse             = commitReg;

endmodule : retimer_lane_mode_control

/* test/retimer_lane_mode_control_asserts.sv */
// Port checker for the lane and mode control register bank.
`timescale 1ns/1ns
module retimer_lane_mode_control_asserts
  import retimer_lane_mode_control_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       hostConfigSelect,
  input wire logic       plugDetectIn,
  input wire logic       plugDetectOut,
  input wire logic       polarityInvert,
  input wire logic [1:0] operatingModeSel,
  input wire logic       commitPulse
);
  // One clock domain, so clock and reset are given once for all properties.
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // Read data changes only as the answer to a read strobe.
  a_rd_data_stands: assert property (!$past(regRead) |-> $stable(regRdData)) else $error("read data moved");
  a_rd_reserved_zero: assert property (regRead && regAddr == 8'h0a |=> regRdData[3:2] == 2'b00)
    else $error("reserved or commit bit read high");
  a_unmapped_zero: assert property (regRead && regAddr != 8'h09 && regAddr != 8'h0a |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  // The pin passes two synchroniser stages, so four low samples guarantee pin mode.
  a_host_off_zero: assert property (regRead && !hostConfigSelect && !$past(hostConfigSelect)
    && !$past(hostConfigSelect, 2) && !$past(hostConfigSelect, 3) |=> regRdData == 8'h00)
    else $error("read answered in pin mode");
  a_commit_cause: assert property (commitPulse |-> $past(regWrite && regAddr == 8'h0a && regWrData[2])
    || $past(regWrite && regAddr == 8'h0a && regWrData[2], 2)) else $error("commit without write");
  a_mode_not_rsvd: assert property (operatingModeSel != 2'b10) else $error("reserved mode applied");
  a_pol_redriver: assert property (polarityInvert |-> operatingModeSel != 2'b00
    || $past(operatingModeSel) != 2'b00) else $error("polarity inverted in redriver mode");
  a_plug_cause: assert property ($rose(plugDetectOut) |-> $past(plugDetectIn, 2))
    else $error("plug output rose without plug");
endmodule : retimer_lane_mode_control_asserts

bind retimer_lane_mode_control retimer_lane_mode_control_asserts i_chk (.*);

/* test/reg_host_model.sv */
// Host model that issues single byte reads and writes on the register port.
`timescale 1ns/1ns
module reg_host_model (
  input  wire logic       core_clk,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  // Strobes idle from time zero so nothing is taken during reset.
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // Released lines show the inverse so stale values cannot pass for new ones.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask : wr

  // Read data stands until the next read, so it is taken a cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge core_clk);
    #1;
    d = regRdData;
  endtask : rd
endmodule : reg_host_model

/* test/tb.sv */
// Self-checking bench for the lane and mode control register bank.
`timescale 1ns/1ns
module tb;
  import retimer_lane_mode_control_pkg::*;
  logic       core_clk, reset, regWrite, regRead, hostConfigSelect, exchangeStrapPin, activityStrapPin;
  logic       plugDetectIn, outputEnablePin, linkClockPresent, laneSwap, polarityInvert, activityDetectEnable;
  logic       powerDown, sinkMode, plugDetectOut, equalizerOn, adaptiveEqualizerSelect, commitPulse;
  logic [1:0] configBusRate, operatingModeSel;
  logic [7:0] regAddr, regWrData, regRdData, rv;
  int         n_mismatch = 0;
  int         compares = 0;
  int         nCommit = 0;

  // Counts commit pulses so that their number and width can be compared.
  always @(posedge core_clk) begin
    if (commitPulse === 1'b1) begin
      nCommit <= nCommit + 1;
    end
  end
  wire [11:0] outs = {laneSwap, polarityInvert, activityDetectEnable, powerDown, sinkMode, plugDetectOut,
                      equalizerOn, adaptiveEqualizerSelect, configBusRate, operatingModeSel};

  retimer_lane_mode_control i_dut (.*);
  reg_host_model i_host (.*);

  // Clock at 50 MHz.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Register read compare and output compare; the settle wait covers synchronisers and apply.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, rv);
    chk("register", {4'h0, exp}, {4'h0, rv});
  endtask : rchk

  task automatic ochk(input logic [11:0] exp);
    repeat (8) @(posedge core_clk);
    #1;
    chk("outputs", exp, outs);
  endtask : ochk

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence: reset, then one test per group of fields.
  initial begin
    {reset, hostConfigSelect, plugDetectIn, outputEnablePin, linkClockPresent} = 5'h1f;
    {exchangeStrapPin, activityStrapPin} = 2'h0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    ochk(12'h0f9);
    rchk(8'h09, 8'h02);
    rchk(8'h0a, 8'hb1);
    rchk(8'h0b, 8'h00);
    $display("test reset done");
    i_host.wr(8'h09, 8'h04);
    i_host.wr(8'h09, 8'hff);
    rchk(8'h09, 8'hdf);
    ochk(12'hffd);
    i_host.wr(8'h09, 8'h06);
    $display("test lane power done");
    i_host.wr(8'h0a, 8'h80);
    ochk(12'h0f9);
    rchk(8'h0a, 8'h80);
    i_host.wr(8'h0a, 8'h84);
    ochk(12'h0c9);
    chk("commit pulses", 12'h001, nCommit[11:0]);
    rchk(8'h0a, 8'h80);
    $display("test commit done");
    i_host.wr(8'h09, 8'h4e);
    i_host.wr(8'h09, 8'h46);
    ochk(12'h0c8);
    i_host.wr(8'h0a, 8'h82);
    rchk(8'h0a, 8'h82);
    i_host.wr(8'h09, 8'h4e);
    i_host.wr(8'h09, 8'h46);
    ochk(12'h0c8);
    i_host.wr(8'h0a, 8'h83);
    i_host.wr(8'h09, 8'h4e);
    i_host.wr(8'h09, 8'h46);
    ochk(12'h4cb);
    $display("test mode done");
    i_host.wr(8'h0a, 8'hb3);
    @(posedge core_clk) plugDetectIn <= 1'b0;
    ochk(12'h4bb);
    i_host.wr(8'h09, 8'h42);
    ochk(12'h5bb);
    @(posedge core_clk) plugDetectIn <= 1'b1;
    ochk(12'h4fb);
    i_host.wr(8'h0a, 8'hf3);
    i_host.wr(8'h0a, 8'hc3);
    ochk(12'h4bb);
    @(posedge core_clk) outputEnablePin <= 1'b0;
    ochk(12'h48b);
    @(posedge core_clk) outputEnablePin <= 1'b1;
    $display("test plug done");
    @(posedge core_clk) {hostConfigSelect, exchangeStrapPin, activityStrapPin} <= 3'h3;
    ochk(12'he8b);
    rchk(8'h09, 8'h00);
    i_host.wr(8'h0a, 8'h00);
    @(posedge core_clk) {exchangeStrapPin, activityStrapPin} <= 2'h0;
    ochk(12'h08b);
    @(posedge core_clk) hostConfigSelect <= 1'b1;
    repeat (4) @(posedge core_clk);
    rchk(8'h0a, 8'hc3);
    rchk(8'h09, 8'h02);
    $display("test pin mode done");
    print_verdict();
  end
endmodule : tb
